// ===== taio_board.sv
`timescale 1ns/1ns
// target board side: weak pull-ups on every pin plus optional board drivers
module taio_board (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe_n,
   input wire logic [2:0] ext_drv,
   input wire logic [2:0] ext_val,
   output logic [2:0] pin_lvl,
   output logic target_soft_reset_n
);
   // port drive wins, else a board driver, else the pull-up keeps the pin high
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : (ext_drv[i] ? ext_val[i] : 1'b1);
      end
   end
   // pin c is wired straight to the target reset input
   assign target_soft_reset_n = pin_lvl[2];
endmodule : taio_board

// ===== taio_defines.svh
`ifndef TAIO_DEFINES_SVH
`define TAIO_DEFINES_SVH

// register offsets on the plain register port
`define TAIO_OFF_CTRL 4'h0
`define TAIO_OFF_DIR 4'h1
`define TAIO_OFF_OUT 4'h2
`define TAIO_OFF_IN 4'h3
`define TAIO_OFF_STAT 4'h4

// control register fields
`define TAIO_CTRL_EN_BIT 0
`define TAIO_CTRL_JTAG_BIT 1
`define TAIO_CTRL_SPI_BIT 2

// status register fields
`define TAIO_STAT_EN_BIT 0
`define TAIO_STAT_REFUSED_BIT 1

// reset values
`define TAIO_CTRL_RST 3'h0
`define TAIO_DIR_RST 3'h0
`define TAIO_OUT_RST 3'h0

// pin count
`define TAIO_PINS 3

`endif

// ===== taio_pkg.sv
package taio_pkg;

   typedef logic [2:0] taio_pins_t;

   // one three-state pin group: output value, output enable (low = drive)
   typedef struct packed {
      taio_pins_t dout;
      taio_pins_t oe_n;
   } taio_drive_s;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } taio_req_s;

   typedef enum logic [1:0] {
      TAIO_OFF,
      TAIO_ON
   } taio_mode_e;

endpackage : taio_pkg

// ===== taio_port.sv
`timescale 1ns/1ns
`include "taio_defines.svh"
module taio_port (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [2:0] aux_pin_in,
   output logic [2:0] aux_pin_out,
   output logic [2:0] aux_pin_oe_n
);
   taio_pkg::taio_req_s req;
   taio_pkg::taio_mode_e mode_r;
   logic jtag_on_r;
   logic spi_on_r;
   logic refused_r;
   logic [2:0] dir_r;
   logic [2:0] out_r;
   logic [2:0] pin_sync;
   taio_pkg::taio_drive_s drv_nxt;
   logic port_en;
   logic en_req;
   logic [7:0] rdata_nxt;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign port_en = (mode_r == taio_pkg::TAIO_ON);

   // pin sampling: pins are outside the clock domain
   taio_sync u_sync (
      .clk(clk),
      .rstn(rstn),
      .d(aux_pin_in),
      .q(pin_sync)
   );

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   // function-select bits; turning jtag or spi on drops the port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         jtag_on_r <= 1'b0;
         spi_on_r <= 1'b0;
      end else if (req.wr && hit(req.addr, `TAIO_OFF_CTRL)) begin
         jtag_on_r <= req.wdata[`TAIO_CTRL_JTAG_BIT];
         spi_on_r <= req.wdata[`TAIO_CTRL_SPI_BIT];
      end
   end

   assign en_req = req.wdata[`TAIO_CTRL_EN_BIT];

   // port enable; refused when the same control write also sets jtag or spi
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= taio_pkg::TAIO_OFF;
      end else if (req.wr && hit(req.addr, `TAIO_OFF_CTRL)) begin
         if (en_req && !req.wdata[`TAIO_CTRL_JTAG_BIT] && !req.wdata[`TAIO_CTRL_SPI_BIT])
            mode_r <= taio_pkg::TAIO_ON;
         else
            mode_r <= taio_pkg::TAIO_OFF;
      end
   end

   // sticky refused flag: set wins over the clear-on-read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refused_r <= 1'b0;
      end else if (req.wr && hit(req.addr, `TAIO_OFF_CTRL) && en_req &&
                   (req.wdata[`TAIO_CTRL_JTAG_BIT] || req.wdata[`TAIO_CTRL_SPI_BIT])) begin
         refused_r <= 1'b1;
      end else if (req.rd && hit(req.addr, `TAIO_OFF_STAT)) begin
         refused_r <= 1'b0;
      end
   end

   // direction and output value registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dir_r <= `TAIO_DIR_RST;
         out_r <= `TAIO_OUT_RST;
      end else if (req.wr) begin
         if (hit(req.addr, `TAIO_OFF_DIR))
            dir_r <= req.wdata[2:0];
         if (hit(req.addr, `TAIO_OFF_OUT))
            out_r <= req.wdata[2:0];
      end
   end

   // next pin drive; disabled port or input pin leaves the line floating
   always_comb begin
      drv_nxt.dout = out_r;
      drv_nxt.oe_n = 3'h7;
      if (port_en)
         drv_nxt.oe_n = ~dir_r;
   end

   // pin outputs from flops; one cycle after the register change
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aux_pin_out <= 3'h0;
         aux_pin_oe_n <= 3'h7;
      end else begin
         aux_pin_out <= drv_nxt.dout;
         aux_pin_oe_n <= drv_nxt.oe_n;
      end
   end

   // read mux; pin levels read as zero while the port is off
   always_comb begin
      rdata_nxt = 8'h00;
      unique case (req.addr)
         `TAIO_OFF_CTRL: rdata_nxt = {5'h00, spi_on_r, jtag_on_r, port_en};
         `TAIO_OFF_DIR: rdata_nxt = {5'h00, dir_r};
         `TAIO_OFF_OUT: rdata_nxt = {5'h00, out_r};
         `TAIO_OFF_IN: rdata_nxt = {5'h00, port_en ? pin_sync : 3'h0};
         `TAIO_OFF_STAT: rdata_nxt = {6'h00, refused_r, port_en};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         rdata <= 8'h00;
      else
         rdata <= req.rd ? rdata_nxt : 8'h00;
   end

   // pin c (target reset) gets no special logic; board wiring only

   a_off_no_drive: assert property (@(posedge clk) disable iff (!rstn)
      !port_en |=> aux_pin_oe_n == 3'h7)
      else $error("pin driven while port disabled");
   a_drive_dir: assert property (@(posedge clk) disable iff (!rstn)
      port_en |=> aux_pin_oe_n == ~$past(dir_r))
      else $error("drive does not follow direction");
   a_refuse_en: assert property (@(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `TAIO_OFF_CTRL && (wdata[1] || wdata[2]))
      |=> !port_en ##1 aux_pin_oe_n == 3'h7)
      else $error("enable accepted with jtag or spi on");
   a_disable_float: assert property (@(posedge clk) disable iff (!rstn)
      $fell(port_en) |=> aux_pin_oe_n == 3'h7)
      else $error("pins not released on disable");
   a_jtag_spi_off: assert property (@(posedge clk) disable iff (!rstn)
      port_en |-> !jtag_on_r && !spi_on_r)
      else $error("port on with jtag or spi");
   a_refused_flag: assert property (@(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `TAIO_OFF_CTRL && wdata[0] && wdata[1]) |=> refused_r)
      else $error("refusal not flagged");
   a_read_pins: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == `TAIO_OFF_IN && port_en) |=> rdata[2:0] == $past(pin_sync))
      else $error("pin level misread");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   a_reset_float: assert property (@(posedge clk)
      !rstn |=> aux_pin_oe_n == 3'h7)
      else $error("pins driven in reset");

   c_enable: cover property (@(posedge clk) disable iff (!rstn) $rose(port_en));
   c_drive_all: cover property (@(posedge clk) disable iff (!rstn) aux_pin_oe_n == 3'h0);
   c_refused: cover property (@(posedge clk) disable iff (!rstn) $rose(refused_r));
   c_disable: cover property (@(posedge clk) disable iff (!rstn) $fell(port_en));

endmodule : taio_port

// ===== taio_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for the pin inputs
module taio_sync (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] d,
   output logic [2:0] q
);
   logic [2:0] meta_r;

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= 3'h0;
         q <= 3'h0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : taio_sync

// ===== testbench.sv
`timescale 1ns/1ns
`include "taio_defines.svh"
module testbench;
   logic clk, rstn, wr, rd, tgt_rst_n;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [2:0] pin_in, pin_out, pin_oe_n, ext_drv, ext_val;
   int fails = 0;
   int cmp_count = 0;
   taio_port taio_port_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .aux_pin_in(pin_in), .aux_pin_out(pin_out),
      .aux_pin_oe_n(pin_oe_n));
   taio_board taio_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drv(ext_drv),
      .ext_val(ext_val), .pin_lvl(pin_in), .target_soft_reset_n(tgt_rst_n));
   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask : chk
   // one-cycle write strobe, changed just after the edge
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe, so look there
   task rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(name, exp, rdata);
   endtask : rd_chk
   // pins follow the register change one edge later
   task oe_chk(input logic [2:0] exp);
      @(posedge clk);
      #1 chk("oe_n", {5'h00, exp}, {5'h00, pin_oe_n});
   endtask : oe_chk
   task t_refuse;
      logic [7:0] codes [2];
      codes = '{8'h03, 8'h05};
      foreach (codes[i]) begin
         wr_reg(`TAIO_OFF_CTRL, codes[i]);
         oe_chk(3'h7);
         rd_chk("stat", `TAIO_OFF_STAT, 8'h02);
         rd_chk("stat_clr", `TAIO_OFF_STAT, 8'h00);
      end
   endtask : t_refuse
   task t_drive;
      ext_drv <= 3'h2;
      ext_val <= 3'h0;
      wr_reg(`TAIO_OFF_DIR, 8'h05);
      wr_reg(`TAIO_OFF_OUT, 8'h01);
      wr_reg(`TAIO_OFF_CTRL, 8'h01);
      oe_chk(3'h2);
      chk("out", 8'h01, {5'h00, pin_out});
      chk("tgt_rst", 8'h00, {7'h00, tgt_rst_n});
      repeat (4) @(posedge clk);
      rd_chk("in", `TAIO_OFF_IN, 8'h01);
      rd_chk("stat_on", `TAIO_OFF_STAT, 8'h01);
      rd_chk("dir", `TAIO_OFF_DIR, 8'h05);
      rd_chk("out_rb", `TAIO_OFF_OUT, 8'h01);
      rd_chk("ctrl_on", `TAIO_OFF_CTRL, 8'h01);
   endtask : t_drive
   task t_disable;
      wr_reg(`TAIO_OFF_CTRL, 8'h00);
      oe_chk(3'h7);
      chk("tgt_rst_off", 8'h01, {7'h00, tgt_rst_n});
      repeat (4) @(posedge clk);
      rd_chk("in_off", `TAIO_OFF_IN, 8'h00);
      // a jtag flag written while the port is on must force it off
      wr_reg(`TAIO_OFF_CTRL, 8'h01);
      oe_chk(3'h2);
      wr_reg(`TAIO_OFF_CTRL, 8'h03);
      oe_chk(3'h7);
      rd_chk("stat_force", `TAIO_OFF_STAT, 8'h02);
      rd_chk("ctrl_force", `TAIO_OFF_CTRL, 8'h02);
      wr_reg(4'hf, 8'hff);
      rd_chk("unmapped", 4'hf, 8'h00);
   endtask : t_disable
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // watchdog well beyond the 71 cycles the tests need
   initial begin
      #20000;
      fails++;
      end_sim();
   end
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      ext_drv = 3'h0;
      ext_val = 3'h0;
      repeat (10) @(posedge clk);
      #1 chk("oe_rst", 8'h07, {5'h00, pin_oe_n});
      rstn <= 1'b1;
      oe_chk(3'h7);
      rd_chk("ctrl_rst", `TAIO_OFF_CTRL, 8'h00);
      t_refuse();
      t_drive();
      t_disable();
      end_sim();
   end
endmodule : testbench
